// ### hdl/cplsp_pkg.sv
// Constants and carrier types for the coprocessor load/store port
package cplsp_pkg;

  // Transfer kinds seen by the core and the coprocessor
  typedef enum logic [2:0] {
    COPROC_LOAD_WORD_XFER    = 3'h0,
    COPROC_LOAD_DOUBLE_XFER  = 3'h1,
    COPROC_STORE_WORD_XFER   = 3'h2,
    COPROC_STORE_DOUBLE_XFER = 3'h3,
    COPROC_FUNCTION_ISSUE    = 3'h4
  } cplsp_kind_t;

  // Access length codes (bytes minus one)
  localparam logic [2:0] WORD_LEN = 3'h3;
  localparam logic [2:0] DWORD_LEN = 3'h7;
  localparam logic [63:0] WORD_MASK = 64'h0000_0000_FFFF_FFFF;

  // Coprocessor numbering
  localparam logic [1:0] SYSTEM_CONTROL_COPROCESSOR = 2'h0;

  // Misaligned support threshold on the architecture revision field
  localparam int AR_W = 3;
  localparam logic [AR_W-1:0] MISALIGN_MIN_REV = 3'h2;

  // Unmapped segment decode and its direct translation
  localparam logic [1:0] UNMAP_SEG = 2'h2;
  localparam int UNMAP_SEG_LSB = 30;
  localparam int UNMAP_UNCACHED_BIT = 29;
  localparam int PA_KEEP_W = 29;
  localparam logic [2:0] CCA_UNCACHED = 3'h2;
  localparam logic [2:0] CCA_CACHED = 3'h3;

  // Lookup qualifiers
  localparam logic DATA_ACCESS = 1'b1;
  localparam logic STORE_ACCESS = 1'b1;

  // Exception codes
  localparam logic [1:0] EXC_XLATE = 2'h0;
  localparam logic [1:0] EXC_MISALIGN_EMU = 2'h1;
  localparam logic [1:0] EXC_ADDR_ERR = 2'h2;
  localparam logic [1:0] EXC_BAD_COP = 2'h3;

  // Register map (byte addresses)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_IRQ_EN = 8'h08;
  localparam logic [7:0] REG_IRQ_CLR = 8'h0C;
  localparam logic [7:0] REG_INFO = 8'h10;
  localparam int CTRL_BE_BIT = 0;
  localparam int CTRL_AR_LSB = 4;
  localparam int INFO_MIS_BIT = 0;
  localparam int INFO_BUSY_BIT = 1;

  // Event bits in status, clear and enable
  localparam int EV_W = 4;
  localparam int EV_DONE = 0;
  localparam int EV_FAULT = 1;
  localparam int EV_MISALIGN = 2;
  localparam int EV_BAD_COP = 3;

  typedef struct packed {
    cplsp_kind_t kind;
    logic [1:0] cop;
    logic [4:0] coproc_register_specifier;
    logic [24:0] func;
    logic [31:0] virtual_addr;
  } cplsp_op_t;

  typedef struct packed {
    logic hit;
    logic allow;
    logic [31:0] paddr;
    logic [2:0] cacheability_attribute;
  } cplsp_xl_rsp_t;

  typedef struct packed {
    logic write;
    logic [31:0] paddr;
    logic [2:0] cacheability_attribute;
    logic [7:0] byte_en;
    logic [63:0] wdata;
  } cplsp_mem_req_t;

  typedef struct packed {
    cplsp_kind_t kind;
    logic [1:0] num;
    logic [4:0] coproc_register_specifier;
    logic [24:0] func;
    logic [63:0] data;
  } cplsp_cp_xfer_t;

endpackage

// ### hdl/cplsp_lanes.sv
// Byte lane selection from access length, low address bits and endianness
module cplsp_lanes import cplsp_pkg::*; (
  input wire logic big_endian, // Byte order of the element
  input wire logic [2:0] access_byte_length, // Bytes minus one
  input wire logic [2:0] addr_lo, // Lowest address bits
  output logic [2:0] shift, // Lowest active lane
  output logic [7:0] byte_en // Active lanes
);
  // Object address is its lowest byte: LSB lane in little, MSB lane in big
  always_comb begin
    if (big_endian) begin
      shift = 3'h7 - addr_lo - access_byte_length;
    end else begin
      shift = addr_lo;
    end
    byte_en = (8'hFF >> (3'h7 - access_byte_length)) << shift;
  end
endmodule // cplsp_lanes

// ### hdl/cplsp_port.sv
// Processor side of the coprocessor load/store and function port
// Summary of operation
// - Load word delivers word, unit, register
// - Load double delivers doubleword, unit, register
// - Function field forwarded to selected coprocessor
// - Coprocessor zero has no load/store transfers
// - Lowest byte address names the object
// - Active lanes from length and address bits
// - Misaligned references complete, here by emulation trap, or address error below revision two
// - Misalign supported when revision at least two
// - Unmapped addresses translate directly, no lookup
// - Mapped addresses use the external translation unit
// - Missing or forbidden translation raises exception
// - Lookup carries instruction/data and load/store flags
// - Steps take effect strictly in order
// - Doubleword access length code is seven
// - Partial store changes only selected bytes
module cplsp_port import cplsp_pkg::*; #(
  parameter int AR_RESET = 2 // Reset value of the architecture revision field
) (
  input wire logic CLOCK, // Core clock
  input wire logic RST_B, // Asynchronous reset, active low
  input wire logic [7:0] REG_ADDR, // Register byte address
  input wire logic [31:0] REG_WDATA, // Register write data
  input wire logic REG_WR, // Register write strobe
  input wire logic REG_RD, // Register read strobe
  output logic [31:0] REG_RDATA, // Read data, cycle after strobe
  input wire logic OP_VALID, // Core request strobe
  input wire cplsp_op_t OP_REQ, // Core request
  output logic OP_BUSY, // Request in progress
  output logic XL_REQ, // Lookup request strobe
  output logic [31:0] XL_VIRTUAL_ADDR, // Lookup virtual address
  output logic XL_INSTR_OR_DATA, // High for data access
  output logic XL_LOAD_OR_STORE, // High for store
  input wire logic XL_ACK, // Lookup answer strobe
  input wire cplsp_xl_rsp_t XL_RSP, // Lookup answer
  output logic MEM_REQ, // Memory request strobe
  output cplsp_mem_req_t MEM_REQ_BUS, // Memory request
  input wire logic MEM_ACK, // Memory answer strobe
  input wire logic [63:0] MEM_RDATA, // Memory element read
  output logic CP_VALID, // Coprocessor strobe
  output cplsp_cp_xfer_t CP_XFER, // Coprocessor transfer
  input wire logic [63:0] CP_SDATA, // Store data, cycle after strobe
  output logic EXC_VALID, // Exception strobe
  output logic [1:0] EXC_CODE, // Exception cause
  output logic IRQ // Level interrupt
);

  if (AR_RESET < 0 || AR_RESET > 7) begin : g_check
    $error("AR_RESET does not fit the revision field");
  end

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_XLATE = 3'h1,
    ST_ISSUE = 3'h2,
    ST_FETCH = 3'h3,
    ST_FWAIT = 3'h4,
    ST_MEM = 3'h5
  } cplsp_state_t;

  typedef struct packed {
    cplsp_state_t st;
    logic busy;
    logic xl_req;
    logic xl_instr_or_data_flag;
    logic xl_load_or_store_flag;
    logic mem_req;
    cplsp_mem_req_t mem;
    logic cp_valid;
    cplsp_cp_xfer_t cp;
    logic exc_valid;
    logic [1:0] exc_code;
    logic irq;
    logic [31:0] rdata;
    logic ctrl_be;
    logic [AR_W-1:0] arch_revision_field;
    logic [EV_W-1:0] status;
    logic [EV_W-1:0] irq_en;
    cplsp_op_t op;
    logic [2:0] len;
    logic be;
    logic [31:0] pa;
    logic [2:0] cca;
  } cplsp_regs_t;

  cplsp_regs_t s;
  cplsp_regs_t next_s;
  logic [2:0] shift;
  logic [7:0] byte_en;
  logic [EV_W-1:0] ev;
  logic [EV_W-1:0] clr;
  logic misalign_supported_check;
  logic is_store;
  logic [63:0] load_data;
  logic [63:0] store_data;
  logic [2:0] req_len;
  logic req_unmapped;

  // Lane choice uses the captured request so it is stable across the access
  cplsp_lanes u_lanes (
    .big_endian(s.be),
    .access_byte_length(s.len),
    .addr_lo(s.op.virtual_addr[2:0]),
    .shift(shift),
    .byte_en(byte_en)
  );

  // Request decode helpers
  always_comb begin
    misalign_supported_check = (s.arch_revision_field >= MISALIGN_MIN_REV);
    is_store = (s.op.kind == COPROC_STORE_WORD_XFER) || (s.op.kind == COPROC_STORE_DOUBLE_XFER);
    req_len = ((OP_REQ.kind == COPROC_LOAD_DOUBLE_XFER) ||
               (OP_REQ.kind == COPROC_STORE_DOUBLE_XFER)) ? DWORD_LEN : WORD_LEN;
    req_unmapped = (OP_REQ.virtual_addr[31:UNMAP_SEG_LSB] == UNMAP_SEG);
    load_data = MEM_RDATA >> {shift, 3'h0};
    if (s.len == WORD_LEN) begin
      load_data = load_data & WORD_MASK;
      store_data = (CP_SDATA & WORD_MASK) << {shift, 3'h0};
    end else begin
      store_data = CP_SDATA << {shift, 3'h0};
    end
  end

  // Next state: register port, sequencer and interrupt status
  always_comb begin
    next_s = s;
    ev = '0;
    clr = '0;
    next_s.xl_req = 1'b0;
    next_s.mem_req = 1'b0;
    next_s.cp_valid = 1'b0;
    next_s.exc_valid = 1'b0;
    next_s.rdata = '0;
    // Register writes; the clear register has no storage of its own
    if (REG_WR) begin
      case (REG_ADDR)
        REG_CTRL: begin
          next_s.ctrl_be = REG_WDATA[CTRL_BE_BIT];
          next_s.arch_revision_field = REG_WDATA[CTRL_AR_LSB +: AR_W];
        end
        REG_IRQ_EN: next_s.irq_en = REG_WDATA[EV_W-1:0];
        REG_IRQ_CLR: clr = REG_WDATA[EV_W-1:0];
        default: ;
      endcase
    end
    // Register reads; unmapped addresses read as zero
    if (REG_RD) begin
      case (REG_ADDR)
        REG_CTRL: begin
          next_s.rdata[CTRL_BE_BIT] = s.ctrl_be;
          next_s.rdata[CTRL_AR_LSB +: AR_W] = s.arch_revision_field;
        end
        REG_STATUS: next_s.rdata[EV_W-1:0] = s.status;
        REG_IRQ_EN: next_s.rdata[EV_W-1:0] = s.irq_en;
        REG_INFO: begin
          next_s.rdata[INFO_MIS_BIT] = misalign_supported_check;
          next_s.rdata[INFO_BUSY_BIT] = s.busy;
        end
        default: ;
      endcase
    end
    // One step per state, each finishing before the next begins
    unique case (s.st)
      ST_IDLE: begin
        if (OP_VALID) begin
          next_s.op = OP_REQ;
          next_s.len = req_len;
          next_s.be = s.ctrl_be;
          next_s.cp.num = OP_REQ.cop;
          next_s.cp.kind = OP_REQ.kind;
          next_s.cp.coproc_register_specifier = OP_REQ.coproc_register_specifier;
          if (OP_REQ.kind == COPROC_FUNCTION_ISSUE) begin
            next_s.cp_valid = 1'b1;
            next_s.cp.func = OP_REQ.func;
            ev[EV_DONE] = 1'b1;
          end else if (OP_REQ.cop == SYSTEM_CONTROL_COPROCESSOR) begin
            next_s.exc_valid = 1'b1;
            next_s.exc_code = EXC_BAD_COP;
            ev[EV_BAD_COP] = 1'b1;
          end else if ((OP_REQ.virtual_addr[2:0] & req_len) != 3'h0) begin
            // Supported parts trap for emulation instead of failing outright
            next_s.exc_valid = 1'b1;
            next_s.exc_code = misalign_supported_check ? EXC_MISALIGN_EMU : EXC_ADDR_ERR;
            ev[EV_MISALIGN] = 1'b1;
          end else if (req_unmapped) begin
            next_s.pa = 32'(OP_REQ.virtual_addr[PA_KEEP_W-1:0]);
            next_s.cca = OP_REQ.virtual_addr[UNMAP_UNCACHED_BIT] ? CCA_UNCACHED : CCA_CACHED;
            next_s.st = ST_ISSUE;
          end else begin
            next_s.xl_req = 1'b1;
            next_s.xl_instr_or_data_flag = DATA_ACCESS;
            next_s.xl_load_or_store_flag = (OP_REQ.kind == COPROC_STORE_WORD_XFER) ||
                             (OP_REQ.kind == COPROC_STORE_DOUBLE_XFER);
            next_s.st = ST_XLATE;
          end
        end
      end
      ST_XLATE: begin
        if (XL_ACK) begin
          if (XL_RSP.hit && XL_RSP.allow) begin
            next_s.pa = XL_RSP.paddr;
            next_s.cca = XL_RSP.cacheability_attribute;
            next_s.st = ST_ISSUE;
          end else begin
            next_s.exc_valid = 1'b1;
            next_s.exc_code = EXC_XLATE;
            ev[EV_FAULT] = 1'b1;
            next_s.st = ST_IDLE;
          end
        end
      end
      ST_ISSUE: begin
        next_s.mem.paddr = s.pa;
        next_s.mem.cacheability_attribute = s.cca;
        next_s.mem.byte_en = byte_en;
        next_s.mem.write = is_store;
        if (is_store) begin
          next_s.cp_valid = 1'b1;
          next_s.st = ST_FETCH;
        end else begin
          next_s.mem_req = 1'b1;
          next_s.st = ST_MEM;
        end
      end
      ST_FETCH: next_s.st = ST_FWAIT;
      ST_FWAIT: begin
        // Coprocessor answers in the cycle after its strobe
        next_s.mem.wdata = store_data;
        next_s.mem_req = 1'b1;
        next_s.st = ST_MEM;
      end
      ST_MEM: begin
        if (MEM_ACK) begin
          if (!is_store) begin
            next_s.cp_valid = 1'b1;
            next_s.cp.data = load_data;
          end
          ev[EV_DONE] = 1'b1;
          next_s.st = ST_IDLE;
        end
      end
      default: next_s.st = ST_IDLE;
    endcase
    next_s.busy = (next_s.st != ST_IDLE);
    // A new event beats a clear in the same cycle
    next_s.status = (s.status & ~clr) | ev;
    next_s.irq = |(next_s.status & next_s.irq_en);
  end

  // All state in one register
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      s <= '0;
      s.arch_revision_field <= AR_W'(AR_RESET);
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from the state register
  assign REG_RDATA = s.rdata;
  assign OP_BUSY = s.busy;
  assign XL_REQ = s.xl_req;
  assign XL_VIRTUAL_ADDR = s.op.virtual_addr;
  assign XL_INSTR_OR_DATA = s.xl_instr_or_data_flag;
  assign XL_LOAD_OR_STORE = s.xl_load_or_store_flag;
  assign MEM_REQ = s.mem_req;
  assign MEM_REQ_BUS = s.mem;
  assign CP_VALID = s.cp_valid;
  assign CP_XFER = s.cp;
  assign EXC_VALID = s.exc_valid;
  assign EXC_CODE = s.exc_code;
  assign IRQ = s.irq;

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_B);

  func_forward_a: assert property (
    (s.st == ST_IDLE && OP_VALID && OP_REQ.kind == COPROC_FUNCTION_ISSUE) |=>
      CP_VALID && CP_XFER.func == $past(OP_REQ.func) && CP_XFER.num == $past(OP_REQ.cop))
    else $error("function code not forwarded");

  cop_zero_a: assert property (
    (s.st == ST_IDLE && OP_VALID && OP_REQ.kind != COPROC_FUNCTION_ISSUE &&
     OP_REQ.cop == SYSTEM_CONTROL_COPROCESSOR) |=>
      EXC_VALID && EXC_CODE == EXC_BAD_COP ##1 !MEM_REQ)
    else $error("transfer to coprocessor zero not refused");

  misalign_code_a: assert property (
    (s.st == ST_IDLE && OP_VALID && OP_REQ.kind != COPROC_FUNCTION_ISSUE &&
     OP_REQ.cop != SYSTEM_CONTROL_COPROCESSOR && OP_REQ.virtual_addr[1:0] != 2'h0) |=>
      EXC_VALID && EXC_CODE == ($past(s.arch_revision_field) >= MISALIGN_MIN_REV ?
                                EXC_MISALIGN_EMU : EXC_ADDR_ERR))
    else $error("misaligned access handled wrongly");

  dword_len_a: assert property (
    (MEM_REQ && (s.op.kind == COPROC_LOAD_DOUBLE_XFER || s.op.kind == COPROC_STORE_DOUBLE_XFER))
      |-> MEM_REQ_BUS.byte_en == 8'hFF)
    else $error("doubleword does not move eight bytes");

  lane_count_a: assert property (
    MEM_REQ |-> $countones(MEM_REQ_BUS.byte_en) == 32'(s.len) + 1)
    else $error("byte enables do not match access length");

  xlate_fail_a: assert property (
    (s.st == ST_XLATE && XL_ACK && !(XL_RSP.hit && XL_RSP.allow)) |=>
      EXC_VALID && EXC_CODE == EXC_XLATE && !OP_BUSY ##1 !MEM_REQ[*2])
    else $error("failed translation did not raise exception");

  unmapped_direct_a: assert property (
    (s.st == ST_IDLE && OP_VALID && req_unmapped && OP_REQ.kind != COPROC_FUNCTION_ISSUE &&
     OP_REQ.cop != SYSTEM_CONTROL_COPROCESSOR && (OP_REQ.virtual_addr[2:0] & req_len) == 3'h0)
      |=> !XL_REQ ##1 MEM_REQ_BUS.paddr == 32'($past(OP_REQ.virtual_addr[PA_KEEP_W-1:0], 2)))
    else $error("unmapped address not translated directly");

  lookup_flags_a: assert property (
    XL_REQ |-> XL_INSTR_OR_DATA == DATA_ACCESS &&
      XL_LOAD_OR_STORE == (s.op.kind == COPROC_STORE_WORD_XFER ||
                           s.op.kind == COPROC_STORE_DOUBLE_XFER))
    else $error("lookup qualifiers wrong");

  load_deliver_a: assert property (
    (s.st == ST_MEM && MEM_ACK && !is_store) |=>
      CP_VALID && CP_XFER.coproc_register_specifier == s.op.coproc_register_specifier ##1 !CP_VALID)
    else $error("loaded data not delivered in one strobe");

  irq_level_a: assert property (
    (ev != '0 && (ev & s.irq_en) != '0) |=> IRQ)
    else $error("enabled event did not raise interrupt");

endmodule // cplsp_port

// ### test/cplsp_cop_model.sv
// Behavioural coprocessor on the far side of the load/store port
module cplsp_cop_model import cplsp_pkg::*; (
  input wire logic clock, // Core clock
  input wire logic rst_b, // Asynchronous reset, active low
  input wire logic cp_valid, // Transfer strobe from the port
  input wire cplsp_cp_xfer_t cp_xfer, // Transfer from the port
  output logic [63:0] cp_sdata // Store data, cycle after strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [63:0] gpr [32];
  logic [4:0] spec;

  assign spec = cp_xfer.coproc_register_specifier;

  // Every strobe is taken at once; the data line scrambles outside the answer cycle
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cp_sdata <= 64'h0;
    end else if (cp_valid && cp_xfer.kind == COPROC_STORE_WORD_XFER) begin
      cp_sdata <= {~gpr[spec][31:0], gpr[spec][31:0]};
    end else if (cp_valid && cp_xfer.kind == COPROC_STORE_DOUBLE_XFER) begin
      cp_sdata <= gpr[spec];
    end else begin
      cp_sdata <= ~cp_sdata;
      if (cp_valid && cp_xfer.kind == COPROC_LOAD_WORD_XFER) begin
        gpr[spec] <= {32'h0, cp_xfer.data[31:0]};
      end
      if (cp_valid && cp_xfer.kind == COPROC_LOAD_DOUBLE_XFER) begin
        gpr[spec] <= cp_xfer.data;
      end
    end
  end
endmodule // cplsp_cop_model

// ### test/cplsp_port_tb_top.sv
// Self-checking bench for the coprocessor load/store port
module cplsp_port_tb_top import cplsp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int AR_RESET_VAL = 2;
  logic clock = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, op_valid = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, xl_virtual_addr, va;
  cplsp_op_t op_req = '0;
  logic op_busy, xl_req, xl_iod, xl_los, xl_ack = 1'b0, mem_req, mem_ack = 1'b0;
  logic cp_valid, exc_valid, irq;
  logic [1:0] exc_code, exc;
  cplsp_xl_rsp_t xl_rsp = '0, xl_set = '0;
  cplsp_mem_req_t mem_bus, mreq;
  logic [63:0] mem_rdata = 64'h0, cp_sdata, mdata;
  cplsp_cp_xfer_t cp_xfer, cpx;
  logic [63:0] cpreg [32];
  logic [24:0] last_fn;
  int n_fail = 0, checks = 0, xl_cnt = 0, mem_cnt = 0;
  logic got_xl, got_mem, got_ack, got_cp, got_exc;

  cplsp_port cplsp_port_i (.CLOCK(clock), .RST_B(rst_b), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
    .OP_VALID(op_valid), .OP_REQ(op_req), .OP_BUSY(op_busy), .XL_REQ(xl_req),
    .XL_VIRTUAL_ADDR(xl_virtual_addr), .XL_INSTR_OR_DATA(xl_iod), .XL_LOAD_OR_STORE(xl_los),
    .XL_ACK(xl_ack), .XL_RSP(xl_rsp), .MEM_REQ(mem_req), .MEM_REQ_BUS(mem_bus),
    .MEM_ACK(mem_ack), .MEM_RDATA(mem_rdata), .CP_VALID(cp_valid), .CP_XFER(cp_xfer),
    .CP_SDATA(cp_sdata), .EXC_VALID(exc_valid), .EXC_CODE(exc_code), .IRQ(irq));
  cplsp_cop_model cplsp_cop_model_i (.clock(clock), .rst_b(rst_b), .cp_valid(cp_valid),
    .cp_xfer(cp_xfer), .cp_sdata(cp_sdata));

  always #4 clock = ~clock;

  // Lookup and memory answer 2 to 4 cycles after the request strobe; answer lines scramble when idle
  always @(posedge clock) begin
    xl_cnt <= xl_req ? 1 + $urandom % 3 : (xl_cnt > 0 ? xl_cnt - 1 : 0);
    mem_cnt <= mem_req ? 1 + $urandom % 3 : (mem_cnt > 0 ? mem_cnt - 1 : 0);
    xl_ack <= (xl_cnt == 1);
    xl_rsp <= (xl_cnt == 1) ? xl_set : ~xl_set;
    mem_ack <= (mem_cnt == 1);
    mem_rdata <= (mem_cnt == 1) ? {$urandom, $urandom} : ~mem_rdata;
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string msg);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s got %0h exp %0h", $time, msg, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string msg);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    chk(reg_rdata, exp, msg);
  endtask

  // One request, then watch every strobe until the port is idle again
  task automatic do_op(input cplsp_kind_t k, input logic [1:0] cp, input logic [4:0] rs,
      input logic [31:0] a);
    int n;
    logic st;
    st = (k == COPROC_STORE_WORD_XFER) || (k == COPROC_STORE_DOUBLE_XFER);
    {got_xl, got_mem, got_ack, got_cp, got_exc} = 5'h00;
    last_fn = 25'($urandom);
    @(posedge clock);
    op_valid <= 1'b1;
    op_req <= '{k, cp, rs, last_fn, a};
    @(posedge clock);
    op_valid <= 1'b0;
    for (n = 0; n < 40; n++) begin
      @(negedge clock);
      if (xl_req === 1'b1) begin
        got_xl = 1'b1;
        chk({xl_virtual_addr, xl_iod, xl_los}, {a, DATA_ACCESS, st}, "lookup request");
      end
      if (mem_req === 1'b1) begin
        got_mem = 1'b1;
        mreq = mem_bus;
      end
      if (mem_ack === 1'b1) begin
        got_ack = 1'b1;
        mdata = mem_rdata;
      end
      if (cp_valid === 1'b1) begin
        got_cp = 1'b1;
        cpx = cp_xfer;
      end
      if (exc_valid === 1'b1) begin
        got_exc = 1'b1;
        exc = exc_code;
      end
      if (op_busy === 1'b0 && (got_exc || (st ? got_ack : got_cp))) break;
    end
    if (n == 40) begin
      $display("[FAIL] %0t operation never finished", $time);
      n_fail++;
      print_verdict();
    end
  endtask

  // Load or store compared with lanes and data worked out here
  task automatic run_ls(input int k, input logic [1:0] cp, input logic [31:0] a,
      input logic be);
    int len, sh;
    logic mapped;
    logic [4:0] rs;
    logic [7:0] ben;
    logic [63:0] lmask, dmask, expd;
    mapped = a[31:30] != UNMAP_SEG;
    len = (k % 2 == 1) ? 7 : 3;
    sh = be ? 7 - int'(a[2:0]) - len : int'(a[2:0]);
    rs = 5'(3 + k % 2);
    dmask = (len == 7) ? '1 : WORD_MASK;
    lmask = 64'h0;
    ben = 8'h00;
    for (int i = 0; i <= len; i++) begin
      lmask[8*(sh+i) +: 8] = 8'hFF;
      ben[sh+i] = 1'b1;
    end
    do_op(cplsp_kind_t'(k), cp, rs, a);
    chk(got_xl, mapped, "lookup use");
    chk({got_mem, mreq.write}, {1'b1, k >= 2}, "memory access");
    chk(mreq.byte_en, ben, "lanes");
    chk(mreq.paddr, mapped ? xl_set.paddr : {3'h0, a[28:0]}, "paddr");
    expd = 64'(mapped ? xl_set.cacheability_attribute : (a[29] ? CCA_UNCACHED : CCA_CACHED));
    chk(mreq.cacheability_attribute, expd, "attribute");
    if (k < 2) begin
      expd = (mdata >> (8 * sh)) & dmask;
      chk(cpx.data, expd, "loaded data");
      chk({cpx.kind, cpx.num}, {3'(k), cp}, "target unit");
      chk(cpx.coproc_register_specifier, rs, "target register");
      cpreg[rs] = expd;
    end else begin
      expd = ((cpreg[rs] & dmask) << (8 * sh)) & lmask;
      chk(mreq.wdata & lmask, expd, "store lanes");
    end
  endtask

  task automatic exc_case(input int k, input logic [1:0] cp, input logic [31:0] a,
      input logic [1:0] code);
    do_op(cplsp_kind_t'(k), cp, 5'h1, a);
    chk({got_exc, got_mem, exc}, {1'b1, 1'b0, code}, "refused request");
  endtask

  initial begin
    void'($urandom(62));
    repeat (20) @(posedge clock);
    rst_b <= 1'b1;
    rd(REG_CTRL, 32'(AR_RESET_VAL << CTRL_AR_LSB), "ctrl reset");
    rd(REG_INFO, 32'h1, "info reset");
    wr(8'h40, 32'hFFFF_FFFF);
    rd(8'h40, 32'h0, "unmapped read");
    rd(REG_STATUS, 32'h0, "status reset");
    rd(REG_IRQ_EN, 32'h0, "enable reset");
    $display("test registers done");
    for (int c = 1; c < 4; c++) begin
      do_op(COPROC_FUNCTION_ISSUE, 2'(c), 5'($urandom), $urandom);
      chk({got_cp, cpx.num, cpx.func}, {1'b1, 2'(c), last_fn}, "func");
      chk(cpx.kind, COPROC_FUNCTION_ISSUE, "func kind");
    end
    $display("test function issue done");
    // Both byte orders, mapped and unmapped, all four transfer kinds
    for (int r = 0; r < 4; r++) begin
      wr(REG_CTRL, 32'h20 | 32'(r % 2));
      for (int k = 0; k < 4; k++) begin
        for (int m = 0; m < 2; m++) begin
          va = {m ? 2'h0 : UNMAP_SEG, 30'($urandom)};
          va[2:0] = (k % 2) ? 3'h0 : {1'($urandom), 2'h0};
          xl_set = '{1'b1, 1'b1, {29'($urandom), va[2:0]}, 3'($urandom)};
          run_ls(k, 2'(1 + $urandom % 3), va, 1'(r % 2));
        end
      end
    end
    $display("test load store done");
    for (int k = 0; k < 4; k++) begin
      exc_case(k, SYSTEM_CONTROL_COPROCESSOR, 32'h8000_0000, EXC_BAD_COP);
    end
    xl_set = '{1'b0, 1'b1, 32'h0000_1000, 3'h3};
    exc_case(0, 2'h1, 32'h0000_1000, EXC_XLATE);
    xl_set = '{1'b1, 1'b0, 32'h0000_1000, 3'h3};
    exc_case(2, 2'h2, 32'h0000_1000, EXC_XLATE);
    exc_case(0, 2'h1, 32'h8000_0001, EXC_MISALIGN_EMU);
    exc_case(1, 2'h1, 32'h8000_0004, EXC_MISALIGN_EMU);
    wr(REG_CTRL, 32'h10);
    rd(REG_INFO, 32'h0, "info at revision one");
    exc_case(0, 2'h1, 32'h8000_0002, EXC_ADDR_ERR);
    wr(REG_CTRL, 32'h20);
    $display("test refusals done");
    rd(REG_STATUS, 32'((1 << EV_W) - 1), "sticky events");
    chk(irq, 1'b0, "masked interrupt");
    wr(REG_IRQ_EN, 32'(1 << EV_FAULT));
    rd(REG_INFO, 32'h1, "info idle");
    chk(irq, 1'b1, "enabled interrupt");
    wr(REG_IRQ_CLR, 32'(1 << EV_FAULT));
    rd(REG_STATUS, 32'(((1 << EV_W) - 1) & ~(1 << EV_FAULT)), "cleared event");
    chk(irq, 1'b0, "interrupt after clear");
    $display("test interrupt done");
    print_verdict();
  end
endmodule // cplsp_port_tb_top
